// ===== verilog/rslt_pkg.sv
// Constants shared by the clock configuration block: register map, field
// positions, reset values and timer divider figures.
// Assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus.
//
// Contract
// [R1] D0 of hour format: 0=12h, 1=24h
// [R2] Hour format register always reads zero
// [R3] 12h BCD hours: 12 midnight, 32 noon
// [R4] Host sets hour format before time setting
// [R5] Leap register: write D2, read phase too
// [R6] Phase 00 with correction on means leap
// [R7] Phase steps 00,01,10,11 per year carry
// [R8] Correction on inserts Feb 29, 1901-2099
// [R9] Correction off: February ends at 28
// [R10] Year digit write clears correction disable
// [R11] Timer register read: top, 0, 0, flag
// [R12] Period top bit 0 disables timer output
// [R13] Watchdog period 562ms halving to 4.39ms
// [R14] Free-running period 625ms halving to 4.883ms
// [R15] Restart bit resets count, new period
// [R16] Output drives pin low; flag mirrors it
// [R17] First output window after restart events
// [R18] Enable low stops timer; high restarts
// [R19] Restart during output ends output at once
// [R20] Periods from binary divider chain taps
package rslt_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [3:0] IDX_HOUR_FMT = 4'ha;
    localparam logic [3:0] IDX_LEAP = 4'hb;
    localparam logic [3:0] IDX_TIMER = 4'hc;
    localparam int ADDR_W = 8;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int HOUR_FMT_BIT = 0;
    localparam int LEAP_DIS_BIT = 2;
    localparam int TIMER_TOP_BIT = 3;
    localparam int TIMER_FLAG_BIT = 0;
    localparam logic RST_HOUR_FMT = 1'b0;
    localparam logic RST_LEAP_DIS = 1'b0;
    localparam logic [1:0] RST_LEAP_PHASE = 2'h0;
    localparam logic [3:0] RST_TIMER_PERIOD = 4'h0;

    // ****************************************************************
    // AXI responses
    // ****************************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************************************
    // Timer divider chain
    // ****************************************************************
    localparam int CLK_HZ = 20000000;
    localparam int PERIOD0_US = 625000;
    // Longest period split into 1280 units so every code gives whole units
    localparam int UNITS_FULL = 1280;
    localparam int UNITS_OUT = 1152;
    localparam int UNIT_CYC = (PERIOD0_US / 1000) * (CLK_HZ / 1000) / UNITS_FULL;
    localparam int UNIT_CNT_W = 11;

    // ****************************************************************
    // Calendar constants
    // ****************************************************************
    localparam logic [7:0] FEB_LAST_LEAP = 8'h29;
    localparam logic [7:0] FEB_LAST_NORMAL = 8'h28;

endpackage

// ===== verilog/rslt_leap.sv
// Leap year phase and February length for the calendar counter.
// Assumes year writes and year carries arrive as one-cycle pulses.
`timescale 1ns/1ps
module rslt_leap
    import rslt_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic dis_wr_i,
    input wire logic dis_val_i,
    input wire logic year_wr_i,
    input wire logic [7:0] year_bcd_i,
    input wire logic year_carry_i,
    output logic disable_o,
    output logic [1:0] phase_o,
    output logic [7:0] feb_last_day_o
);
    logic dis_r;
    logic dis_nxt;
    logic [1:0] phase_r;
    logic [1:0] phase_nxt;
    logic [7:0] feb_r;
    logic [7:0] feb_nxt;

    always_comb begin
        dis_nxt = dis_r;
        phase_nxt = phase_r;
        if (dis_wr_i) begin
            dis_nxt = dis_val_i;
        end
        // Year write wins over a same-cycle software set
        if (year_wr_i) begin
            dis_nxt = 1'b0; // [R10]
            // Year mod 4 from BCD keeps every fourth year leap across 1901-2099
            phase_nxt = year_bcd_i[1:0] + {year_bcd_i[4], 1'b0}; // [R8]
        end else if (year_carry_i) begin
            phase_nxt = phase_r + 2'h1; // [R7]
        end
        if (!dis_nxt && phase_nxt == 2'h0) begin
            feb_nxt = FEB_LAST_LEAP; // [R6] [R8]
        end else begin
            feb_nxt = FEB_LAST_NORMAL; // [R9]
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            dis_r <= RST_LEAP_DIS;
            phase_r <= RST_LEAP_PHASE;
            feb_r <= FEB_LAST_LEAP;
        end else begin
            dis_r <= dis_nxt;
            phase_r <= phase_nxt;
            feb_r <= feb_nxt;
        end
    end

    assign disable_o = dis_r;
    assign phase_o = phase_r;
    assign feb_last_day_o = feb_r;
endmodule

// ===== verilog/rslt_wdt.sv
// Watchdog / free-running timer with an open-drain style output.
// Assumes restart arrives as a one-cycle pulse; enable is a level.
`timescale 1ns/1ps
module rslt_wdt
    import rslt_pkg::*;
#(
    parameter int UNIT_CYCLES = UNIT_CYC
)
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [3:0] period_i,
    input wire logic restart_i,
    input wire logic enable_i,
    output logic flag_o,
    output logic pin_o,
    output logic pin_oe_o
);
    logic [31:0] pre_r;
    logic [31:0] pre_nxt;
    logic [UNIT_CNT_W-1:0] cnt_r;
    logic [UNIT_CNT_W-1:0] cnt_nxt;
    logic act_r;
    logic act_nxt;
    logic en_d_r;
    logic [UNIT_CNT_W-1:0] full;
    logic [UNIT_CNT_W-1:0] thr;
    logic run;
    logic restart_evt;
    logic tick;

    always_comb begin
        // Each code step takes the next binary tap, halving the period
        full = UNIT_CNT_W'(UNITS_FULL) >> period_i[2:0]; // [R20] [R14]
        thr = UNIT_CNT_W'(UNITS_OUT) >> period_i[2:0]; // [R20] [R13]
        run = enable_i && period_i[TIMER_TOP_BIT]; // [R12] [R18]
        restart_evt = restart_i || (enable_i && !en_d_r); // [R15] [R17] [R18]
        tick = (pre_r == 32'(UNIT_CYCLES - 1));
        pre_nxt = pre_r;
        cnt_nxt = cnt_r;
        act_nxt = act_r;
        if (!run || restart_evt) begin
            pre_nxt = 32'h0;
            cnt_nxt = '0;
            act_nxt = 1'b0; // [R19]
        end else if (tick) begin
            pre_nxt = 32'h0;
            if (cnt_r + 1'b1 == full) begin
                cnt_nxt = '0;
                act_nxt = 1'b0; // [R14]
            end else begin
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r + 1'b1 == thr) begin
                    act_nxt = 1'b1; // [R13] [R17]
                end
            end
        end else begin
            pre_nxt = pre_r + 32'h1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pre_r <= 32'h0;
            cnt_r <= '0;
            act_r <= 1'b0;
            en_d_r <= 1'b1;
        end else begin
            pre_r <= pre_nxt;
            cnt_r <= cnt_nxt;
            act_r <= act_nxt;
            en_d_r <= enable_i;
        end
    end

    // Open drain: only ever pulls low
    assign pin_o = 1'b0; // [R16]
    assign pin_oe_o = act_r; // [R16]
    assign flag_o = act_r; // [R16]
endmodule

// ===== verilog/rslt_top.sv
// Hour scale, leap year and timer configuration of the clock, with an
// AXI4-Lite register slave.
// Assumes the time and calendar counters sit outside and exchange hour,
// year and carry signals with this block on the same clock.
`timescale 1ns/1ps
module rslt_top
    import rslt_pkg::*;
#(
    parameter int UNIT_CYCLES = UNIT_CYC
)
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [4:0] hour24_i,
    input wire logic year_wr_i,
    input wire logic [7:0] year_bcd_i,
    input wire logic year_carry_i,
    input wire logic timer_restart_i,
    input wire logic iface_enable_i,
    output logic [7:0] hour_bcd_o,
    output logic hour_24h_o,
    output logic [7:0] feb_last_day_o,
    output logic [1:0] leap_phase_o,
    output logic timer_output_pin_o,
    output logic timer_output_pin_oe_o,
    output logic timer_output_flag_o
);

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] addr);
        logic [1:0] sel;
        sel = 2'h0;
        if (addr == ADDR_W'({IDX_HOUR_FMT, 2'b00})) begin
            sel = 2'h1;
        end else if (addr == ADDR_W'({IDX_LEAP, 2'b00})) begin
            sel = 2'h2;
        end else if (addr == ADDR_W'({IDX_TIMER, 2'b00})) begin
            sel = 2'h3;
        end
        return sel;
    endfunction

    function automatic logic [7:0] to_bcd(input logic [4:0] val);
        logic [4:0] ones;
        logic [3:0] tens;
        tens = 4'h0;
        ones = val;
        if (val >= 5'h14) begin
            tens = 4'h2;
            ones = val - 5'h14;
        end else if (val >= 5'h0a) begin
            tens = 4'h1;
            ones = val - 5'h0a;
        end
        return {tens, ones[3:0]};
    endfunction

    // ****************************************************************
    // Write channel state
    // ****************************************************************
    logic aw_held_r;
    logic aw_held_nxt;
    logic w_held_r;
    logic w_held_nxt;
    logic [ADDR_W-1:0] awaddr_r;
    logic [ADDR_W-1:0] awaddr_nxt;
    logic [3:0] wnib_r;
    logic [3:0] wnib_nxt;
    logic wlane_r;
    logic wlane_nxt;
    logic bvalid_r;
    logic bvalid_nxt;
    logic [1:0] bresp_r;
    logic [1:0] bresp_nxt;
    logic wr_go;

    // ****************************************************************
    // Read channel state
    // ****************************************************************
    logic rvalid_r;
    logic rvalid_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [1:0] rresp_r;
    logic [1:0] rresp_nxt;

    // ****************************************************************
    // Configuration state
    // ****************************************************************
    logic fmt_r;
    logic fmt_nxt;
    logic [3:0] period_r;
    logic [3:0] period_nxt;
    logic per_wr_r;
    logic per_wr_nxt;
    logic leap_wr;
    logic [7:0] hour_r;
    logic [7:0] hour_nxt;
    logic leap_dis;
    logic [1:0] leap_phase;
    logic tmr_flag;

    assign s_axi_awready = !aw_held_r;
    assign s_axi_wready = !w_held_r;
    assign s_axi_arready = !rvalid_r;
    assign wr_go = aw_held_r && w_held_r && !bvalid_r;

    // ****************************************************************
    // Write path
    // ****************************************************************
    always_comb begin
        aw_held_nxt = aw_held_r;
        w_held_nxt = w_held_r;
        awaddr_nxt = awaddr_r;
        wnib_nxt = wnib_r;
        wlane_nxt = wlane_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        fmt_nxt = fmt_r;
        period_nxt = period_r;
        per_wr_nxt = 1'b0;
        leap_wr = 1'b0;
        if (s_axi_awvalid && !aw_held_r) begin
            aw_held_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held_r) begin
            w_held_nxt = 1'b1;
            wnib_nxt = s_axi_wdata[3:0];
            wlane_nxt = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (wr_go) begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = RESP_OKAY;
            case (reg_sel(awaddr_r))
                2'h1: begin
                    if (wlane_r) begin
                        fmt_nxt = wnib_r[HOUR_FMT_BIT]; // [R1]
                    end
                end
                2'h2: begin
                    leap_wr = wlane_r; // [R5]
                end
                2'h3: begin
                    if (wlane_r) begin
                        period_nxt = wnib_r;
                        // A new period setting restarts the count cleanly
                        per_wr_nxt = 1'b1; // [R17]
                    end
                end
                default: begin
                    bresp_nxt = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wnib_r <= 4'h0;
            wlane_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            fmt_r <= RST_HOUR_FMT;
            period_r <= RST_TIMER_PERIOD;
            per_wr_r <= 1'b0;
        end else begin
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            awaddr_r <= awaddr_nxt;
            wnib_r <= wnib_nxt;
            wlane_r <= wlane_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            fmt_r <= fmt_nxt;
            period_r <= period_nxt;
            per_wr_r <= per_wr_nxt;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // ****************************************************************
    // Read path
    // ****************************************************************
    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = RESP_OKAY;
            rdata_nxt = 32'h0;
            case (reg_sel(s_axi_araddr))
                2'h1: begin
                    // Format bit is write only; the scale shows on hour_24h_o
                    rdata_nxt = 32'h0; // [R2]
                end
                2'h2: begin
                    rdata_nxt = {29'h0, leap_dis, leap_phase}; // [R5]
                end
                2'h3: begin
                    rdata_nxt = {28'h0, period_r[TIMER_TOP_BIT], 2'h0, tmr_flag}; // [R11]
                end
                default: begin
                    rresp_nxt = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= RESP_OKAY;
        end else begin
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // ****************************************************************
    // Hour encoding
    // ****************************************************************
    always_comb begin
        if (fmt_r) begin
            hour_nxt = to_bcd(hour24_i); // [R1]
        end else if (hour24_i == 5'h00) begin
            hour_nxt = 8'h12; // [R3]
        end else if (hour24_i < 5'h0c) begin
            hour_nxt = to_bcd(hour24_i); // [R3]
        end else if (hour24_i == 5'h0c) begin
            hour_nxt = 8'h32; // [R3]
        end else begin
            // Afternoon: hour minus twelve with the pm bit (BCD 20) set
            hour_nxt = to_bcd(hour24_i - 5'h0c) | 8'h20; // [R3]
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            hour_r <= 8'h12;
        end else begin
            hour_r <= hour_nxt;
        end
    end

    assign hour_bcd_o = hour_r;
    assign hour_24h_o = fmt_r;
    assign leap_phase_o = leap_phase;

    // ****************************************************************
    // Leap year and timer
    // ****************************************************************
    rslt_leap u_leap (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .dis_wr_i(leap_wr),
        .dis_val_i(wnib_r[LEAP_DIS_BIT]),
        .year_wr_i(year_wr_i),
        .year_bcd_i(year_bcd_i),
        .year_carry_i(year_carry_i),
        .disable_o(leap_dis),
        .phase_o(leap_phase),
        .feb_last_day_o(feb_last_day_o)
    );

    rslt_wdt #(
        .UNIT_CYCLES(UNIT_CYCLES)
    ) u_wdt (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .period_i(period_r),
        .restart_i(timer_restart_i || per_wr_r), // [R15]
        .enable_i(iface_enable_i),
        .flag_o(tmr_flag),
        .pin_o(timer_output_pin_o),
        .pin_oe_o(timer_output_pin_oe_o)
    );

    assign timer_output_flag_o = tmr_flag;
endmodule

// ===== tb/rslt_top_monitor.sv
// Concurrent checks on the ports of the clock configuration block.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module rslt_top_monitor (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic year_wr_i,
    input wire logic year_carry_i,
    input wire logic timer_restart_i,
    input wire logic iface_enable_i,
    input wire logic [1:0] leap_phase_o,
    input wire logic [7:0] feb_last_day_o,
    input wire logic timer_output_pin_o,
    input wire logic timer_output_pin_oe_o,
    input wire logic timer_output_flag_o
);
    // ****************
    // Checks
    // ****************
    default clocking mon_cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // Phase non-zero and held a second cycle; February length updates on the same edge as phase
    sequence s_odd_phase;
        leap_phase_o != 2'h0 ##1 $stable(leap_phase_o);
    endsequence

    a_write_resp_due: assert property (s_wr_both |-> ##2 s_axi_bvalid)
        else $error("write response not on time");
    a_read_data_due: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read data not on time");
    a_bresp_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not retired");
    a_rresp_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data not retired");
    a_pin_drives_low: assert property (timer_output_pin_o == 1'b0)
        else $error("timer pin data not low");
    a_flag_mirrors_pin: assert property (timer_output_flag_o == timer_output_pin_oe_o)
        else $error("timer flag differs from pin");
    a_enable_stops_out: assert property (!iface_enable_i |=> !timer_output_pin_oe_o)
        else $error("timer active while interface disabled");
    a_restart_ends_out: assert property (timer_restart_i && timer_output_pin_oe_o |=> !timer_output_pin_oe_o)
        else $error("restart did not end timer output");
    a_phase_step: assert property (year_carry_i && !year_wr_i |=> leap_phase_o == 2'($past(leap_phase_o) + 2'h1))
        else $error("leap phase did not step");
    a_normal_feb: assert property (s_odd_phase |-> feb_last_day_o == 8'h28)
        else $error("february long in normal year");
endmodule

// ===== tb/rslt_host.sv
// Host model: AXI4-Lite master plus the restart strobe of control register one.
// Assumes every task is entered right after a rising clock edge.
`timescale 1ns/1ps
module rslt_host (
    input wire logic clk_sys_i,
    output logic [7:0] awaddr_o,
    output logic awvalid_o,
    input wire logic awready_i,
    output logic [31:0] wdata_o,
    output logic [3:0] wstrb_o,
    output logic wvalid_o,
    input wire logic wready_i,
    input wire logic [1:0] bresp_i,
    input wire logic bvalid_i,
    output logic bready_o,
    output logic [7:0] araddr_o,
    output logic arvalid_o,
    input wire logic arready_i,
    input wire logic [31:0] rdata_i,
    input wire logic [1:0] rresp_i,
    input wire logic rvalid_i,
    output logic rready_o,
    output logic restart_o
);
    // ****************
    // Bus cycles
    // ****************
    initial begin
        {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
        {araddr_o, arvalid_o, rready_o, restart_o} = '0;
    end

    // Released payload is inverted so stale values cannot pass for fresh ones
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr_o <= a;
        wdata_o <= d;
        wstrb_o <= 4'hf;
        awvalid_o <= 1'b1;
        wvalid_o <= 1'b1;
        bready_o <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk_sys_i);
            if (!aw_ok && awready_i) begin
                aw_ok = 1'b1;
                awvalid_o <= 1'b0;
                awaddr_o <= ~a;
            end
            if (!w_ok && wready_i) begin
                w_ok = 1'b1;
                wvalid_o <= 1'b0;
                wdata_o <= ~d;
            end
        end
        do @(posedge clk_sys_i); while (!bvalid_i);
        r = bresp_i;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr_o <= a;
        arvalid_o <= 1'b1;
        rready_o <= 1'b1;
        do @(posedge clk_sys_i); while (!arready_i);
        arvalid_o <= 1'b0;
        araddr_o <= ~a;
        do @(posedge clk_sys_i); while (!rvalid_i);
        d = rdata_i;
        r = rresp_i;
    endtask

    // Restart bit write reaches the block as a one-cycle strobe
    task automatic kick();
        restart_o <= 1'b1;
        @(posedge clk_sys_i);
        restart_o <= 1'b0;
    endtask
endmodule

// ===== tb/test_rtc_scale_leap_timer_config.sv
// Self-checking bench for hour scale, leap year and timer configuration.
// Assumes rslt_host drives the register bus; the monitor is bound below.
`timescale 1ns/1ps
module test_rtc_scale_leap_timer_config import rslt_pkg::*;;
    // Small unit keeps the longest timer cycle at 5120 clocks
    localparam int UC = 4;
    localparam logic [7:0] A_HF = {2'h0, IDX_HOUR_FMT, 2'h0};
    localparam logic [7:0] A_LY = {2'h0, IDX_LEAP, 2'h0};
    localparam logic [7:0] A_TM = {2'h0, IDX_TIMER, 2'h0};
    logic clk_sys_i, rst_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, year_wr_i, year_carry_i;
    logic timer_restart_i, iface_enable_i, hour_24h_o, timer_output_pin_o, timer_output_pin_oe_o;
    logic timer_output_flag_o;
    logic [7:0] s_axi_awaddr, s_axi_araddr, year_bcd_i, hour_bcd_o, feb_last_day_o;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, leap_phase_o, r;
    logic [4:0] hour24_i;
    int err_total, check_count, seed, n, p, y;

    rslt_top #(.UNIT_CYCLES(UC)) dut_u (.*);
    rslt_host host_u (.clk_sys_i(clk_sys_i), .awaddr_o(s_axi_awaddr), .awvalid_o(s_axi_awvalid),
        .awready_i(s_axi_awready), .wdata_o(s_axi_wdata), .wstrb_o(s_axi_wstrb), .wvalid_o(s_axi_wvalid),
        .wready_i(s_axi_wready), .bresp_i(s_axi_bresp), .bvalid_i(s_axi_bvalid), .bready_o(s_axi_bready),
        .araddr_o(s_axi_araddr), .arvalid_o(s_axi_arvalid), .arready_i(s_axi_arready),
        .rdata_i(s_axi_rdata), .rresp_i(s_axi_rresp), .rvalid_i(s_axi_rvalid), .rready_o(s_axi_rready),
        .restart_o(timer_restart_i));

    // ****************
    // Helpers
    // ****************
    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        if (err_total == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    function automatic logic [7:0] bcd(input int x);
        return 8'((x / 10) * 16 + x % 10);
    endfunction

    function automatic logic [7:0] h12(input int h);
        int k;
        k = (h % 12 == 0) ? 12 : h % 12;
        return 8'(bcd(k) + ((h >= 12) ? 8'h20 : 8'h00));
    endfunction

    // Cycles until the timer flag is seen high, capped at lim
    task automatic wait_flag(input int lim, output int c);
        c = 0;
        do begin
            @(posedge clk_sys_i);
            c++;
        end while (timer_output_flag_o !== 1'b1 && c < lim);
    endtask

    initial begin
        #(50000 * 50);
        err_total++;
        end_of_test();
    end

    // ****************
    // Scenarios
    // ****************
    initial begin
        {seed, err_total, check_count} = {32'h4a3c1d7a, 64'h0};
        {rst_i, hour24_i, year_wr_i, year_carry_i, year_bcd_i, iface_enable_i} = {1'b1, 15'h0, 1'b1};
        repeat (4) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        host_u.rd(A_LY, v, r);
        chk(v, 32'h0);
        chk(32'(feb_last_day_o), 32'h29);
        for (int f = 0; f < 2; f++) begin
            host_u.wr(A_HF, ({$random(seed)} & 32'hfffffffe) | 32'(f), r);
            for (int h = 0; h < 24; h++) begin
                hour24_i <= 5'(h);
                repeat (2) @(posedge clk_sys_i);
                chk(32'(hour_bcd_o), 32'(f ? bcd(h) : h12(h)));
            end
            chk(32'(hour_24h_o), 32'(f));
            host_u.rd(A_HF, v, r);
            chk(v, 32'h0);
        end
        host_u.wr(8'h3c, 32'h1, r);
        chk(32'(r), 32'(RESP_SLVERR));
        host_u.rd(8'h00, v, r);
        chk(v ^ 32'(r), 32'(RESP_SLVERR));
        host_u.wr(A_LY, 32'h4, r);
        for (int i = 1; i < 6; i++) begin
            year_carry_i <= 1'b1;
            @(posedge clk_sys_i);
            year_carry_i <= 1'b0;
            repeat (2) @(posedge clk_sys_i);
            chk(32'(leap_phase_o), 32'(i % 4));
            chk(32'(feb_last_day_o), 32'h28);
        end
        host_u.rd(A_LY, v, r);
        chk(v, 32'h5);
        for (int i = 0; i < 8; i++) begin
            y = (i == 0) ? 0 : (i == 1) ? 99 : int'({$random(seed)} % 100);
            host_u.wr(A_LY, 32'h4, r);
            year_bcd_i <= bcd(y);
            year_wr_i <= 1'b1;
            @(posedge clk_sys_i);
            year_wr_i <= 1'b0;
            repeat (2) @(posedge clk_sys_i);
            chk(32'(feb_last_day_o), (y % 4 == 0) ? 32'h29 : 32'h28);
            host_u.rd(A_LY, v, r);
            chk(v, 32'(y % 4));
        end
        for (int c = 0; c < 8; c++) begin
            host_u.wr(A_TM, 32'(8 + c), r);
            host_u.kick();
            wait_flag(6000, n);
            chk(32'(n >= (1152 >> c) * UC && n <= (1280 >> c) * UC), 32'h1);
            p = 0;
            do begin
                @(posedge clk_sys_i);
                p++;
            end while (timer_output_flag_o === 1'b1 && p < 6000);
            wait_flag(6000, n);
            chk(32'(p + n), 32'((1280 >> c) * UC));
            if (c < 4) begin
                host_u.rd(A_TM, v, r);
                chk(v, 32'h9);
            end
            host_u.kick();
            @(posedge clk_sys_i);
            chk(32'(timer_output_flag_o), 32'h0);
        end
        host_u.wr(A_TM, 32'h7, r);
        wait_flag(300, n);
        chk(32'(n), 32'h12c);
        host_u.rd(A_TM, v, r);
        chk(v, 32'h0);
        host_u.wr(A_TM, 32'hf, r);
        iface_enable_i <= 1'b0;
        wait_flag(100, n);
        chk(32'(n), 32'h64);
        iface_enable_i <= 1'b1;
        wait_flag(100, n);
        chk(32'(n >= 9 * UC && n <= 10 * UC), 32'h1);
        end_of_test();
    end
endmodule

bind rslt_top rslt_top_monitor mon_u (.*);
